// file: logic/atz_pkg.sv
// Purpose: constants shared by the front-end trim and settle register bank
// Assumes: register indices are word indices, byte address is four times each
// Notes:   all counts, offsets and reset values live here

package atz_pkg;

    // register word indices
    localparam logic [7:0] IDX_FINE = 8'h46; // fine offset override
    localparam logic [7:0] IDX_IVL  = 8'h47; // offset update interval
    localparam logic [7:0] IDX_EXT  = 8'h48; // extrapolation run time
    localparam logic [7:0] IDX_FWS  = 8'h4c; // functional wake settle
    localparam logic [7:0] IDX_SUP  = 8'h4d; // startup settle upper
    localparam logic [7:0] IDX_SLO  = 8'h4e; // startup settle lower
    localparam logic [7:0] IDX_LPS  = 8'h4f; // low-power wake settle
    localparam logic [7:0] IDX_IXU  = 8'h50; // index offset upper
    localparam logic [7:0] IDX_IXL  = 8'h51; // index offset lower

    // field positions
    localparam int OVR_BIT  = 15; // override enable bit
    localparam int CODE_W   = 8;  // fine offset code width
    localparam int SUP_W    = 3;  // startup upper field width
    localparam int IXU_W    = 4;  // index upper field width
    localparam int ANGLE_W  = 20; // angle width
    localparam int SETTLE_W = 19; // startup settle width

    // values after reset
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SUP  = 16'h0006;
    localparam logic [15:0] RST_SLO  = 16'h1a80;

    // offset dac step in microvolts
    localparam logic signed [15:0] STEP_UV = 16'sh00fa; // 250 uV

    // interval unit: 2 us at the 40 MHz analog timebase = 80 cycles
    localparam int TICK_NS    = 2000;
    localparam int TBASE_NS   = 25;
    localparam logic [6:0] TICK_CYC = 7'(TICK_NS / TBASE_NS);

    // settle sequencer states
    typedef enum logic [1:0] {
        ST_START = 2'b00, // initial startup hold
        ST_RUN   = 2'b01, // normal operation
        ST_WAKE  = 2'b10  // hold after sleep to functional
    } atz_seq_t;

endpackage

// file: logic/atz_regs.sv
// Purpose: trim, offset timing, settle and index offset register bank
// Assumes: one clock, Avalon-MM slave with waitrequest, byte address
// Notes:   answers every access one cycle after it is seen
//
// How it works
// RULE1 - override bit forces fine dac, stops auto
// RULE2 - fine code is signed, 250 uV steps
// RULE3 - both controllers update each interval times 80
// RULE4 - zero interval disables all automatic updates
// RULE5 - extrapolator runs run-time times 80 cycles
// RULE6 - zero run time never starts extrapolator
// RULE7 - functional wake holds for programmed cycles
// RULE8 - startup hold uses 19-bit count, given defaults
// RULE9 - battery low-power wake holds dsp sequencing
// RULE10 - 20-bit index offset shifts mechanical angle
// RULE11 - index offset kept in non-volatile memory; the store pulse carries the offset from before the write
// RULE12 - reserved bits read zero, writes ignored

`timescale 1ns/1ps

module atz_regs
    import atz_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [9:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic      [31:0]  avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic [7:0]   auto_fine_code,
    input  wire logic         qual_evt,
    input  wire logic         wake_func,
    input  wire logic         wake_lp,
    input  wire logic         batt_mode,
    input  wire logic [19:0]  mech_angle,
    input  wire logic         nvm_load,
    input  wire logic [19:0]  nvm_index,
    output logic      [7:0]   fine_dac,
    output logic              fine_ovr,
    output logic signed [15:0] fine_uv,
    output logic              fine_upd,
    output logic              coarse_upd,
    output logic              extrap_run,
    output logic              seq_hold,
    output logic              dsp_hold,
    output logic      [19:0]  pos_out,
    output logic      [19:0]  nvm_index_out,
    output logic              nvm_store
);

    // register storage, only the documented bits
    logic               ovr_q;  // override enable
    logic [CODE_W-1:0]  code_q; // fine offset code
    logic [15:0]        ivl_q;  // update interval
    logic [15:0]        ext_q;  // extrapolation run time
    logic [15:0]        fws_q;  // functional settle cycles
    logic [SUP_W-1:0]   sup_q;  // startup settle upper
    logic [15:0]        slo_q;  // startup settle lower
    logic [15:0]        lps_q;  // low-power settle cycles
    logic [IXU_W-1:0]   ixu_q;  // index offset upper
    logic [15:0]        ixl_q;  // index offset lower

    // bus handshake
    logic        req;     // a request is present
    logic [7:0]  widx;    // word index of the access
    logic        wr;      // write takes effect
    logic [15:0] wdat;    // write data merged by lane
    logic [15:0] rd_d;    // read mux

    assign req  = avs_read | avs_write;
    assign widx = avs_address[9:2];
    assign wr   = ce & avs_write & ~avs_waitrequest;

    // merge byte lanes into a 16-bit value, upper lanes unused
    function automatic logic [15:0] lanes(input logic [15:0] old);
        logic [15:0] r;
        r = old;
        if (avs_byteenable[0]) begin
            r[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            r[15:8] = avs_writedata[15:8];
        end
        return r;
    endfunction

    // old value of the addressed word with the enabled lanes laid over it;
    // reserved bits come in as zero from the read mux and are dropped on store
    always_comb begin
        wdat = lanes(rd_d);
    end

    // waitrequest high for one cycle, then low for one: one-wait answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            avs_waitrequest <= ~(req & avs_waitrequest);
        end
    end

    // read mux, reserved bits come back as zero; see RULE12
    always_comb begin
        rd_d = 16'h0000;
        unique case (widx)
            IDX_FINE: rd_d = {ovr_q, 7'h00, code_q};
            IDX_IVL:  rd_d = ivl_q;
            IDX_EXT:  rd_d = ext_q;
            IDX_FWS:  rd_d = fws_q;
            IDX_SUP:  rd_d = {13'h0000, sup_q};
            IDX_SLO:  rd_d = slo_q;
            IDX_LPS:  rd_d = lps_q;
            IDX_IXU:  rd_d = {12'h000, ixu_q};
            IDX_IXL:  rd_d = ixl_q;
            default:  rd_d = 16'h0000; // unmapped reads zero
        endcase
    end

    // read data captured in the wait cycle, stands while waitrequest low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && avs_waitrequest) begin
            avs_readdata <= {16'h0000, rd_d};
        end
    end

    // register writes; unmapped and reserved bits are dropped; see RULE12
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovr_q  <= 1'b0;
            code_q <= RST_ZERO[CODE_W-1:0];
            ivl_q  <= RST_ZERO;
            ext_q  <= RST_ZERO;
            fws_q  <= RST_ZERO;
            sup_q  <= RST_SUP[SUP_W-1:0];     // see RULE8
            slo_q  <= RST_SLO;                // see RULE8
            lps_q  <= RST_ZERO;
        end else if (wr) begin
            unique case (widx)
                IDX_FINE: begin
                    ovr_q  <= wdat[OVR_BIT];
                    code_q <= wdat[CODE_W-1:0];
                end
                IDX_IVL: ivl_q <= wdat;
                IDX_EXT: ext_q <= wdat;
                IDX_FWS: fws_q <= wdat;
                IDX_SUP: sup_q <= wdat[SUP_W-1:0];
                IDX_SLO: slo_q <= wdat;
                IDX_LPS: lps_q <= wdat;
                default: ;                    // other indices ignored
            endcase
        end
    end

    // index offset; a bus write wins over an nvm restore that same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ixu_q <= RST_ZERO[IXU_W-1:0];
            ixl_q <= RST_ZERO;
        end else if (wr && widx == IDX_IXU) begin
            ixu_q <= wdat[IXU_W-1:0];          // see RULE12
        end else if (wr && widx == IDX_IXL) begin
            ixl_q <= wdat;
        end else if (ce && nvm_load) begin
            ixu_q <= nvm_index[ANGLE_W-1:16];  // see RULE11
            ixl_q <= nvm_index[15:0];          // see RULE11
        end
    end

    // both halves go to nvm on any write of either, as they stood before that write; see RULE11
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_store     <= 1'b0;
            nvm_index_out <= 20'h00000;
        end else if (ce) begin
            nvm_store     <= wr && (widx == IDX_IXU || widx == IDX_IXL);
            nvm_index_out <= {ixu_q, ixl_q};
        end
    end

    // custom zero: offset subtracted so writing the angle reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_out <= 20'h00000;
        end else if (ce) begin
            pos_out <= mech_angle - {ixu_q, ixl_q};   // see RULE10
        end
    end

    // fine dac source: override code or automatic code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fine_dac <= 8'h00;
            fine_ovr <= 1'b0;
            fine_uv  <= 16'sh0000;
        end else if (ce) begin
            fine_ovr <= ovr_q;
            fine_dac <= ovr_q ? code_q : auto_fine_code;   // see RULE1
            // signed code times step, fits 16 bits; see RULE2
            fine_uv  <= 16'($signed({{8{code_q[7]}}, code_q}) * STEP_UV);
        end
    end

    // interval timebase: 80-cycle tick, then count ticks
    logic [6:0]  upre_q;  // cycles inside one tick
    logic [15:0] ucnt_q;  // ticks inside one interval
    logic        utick;   // last cycle of a tick

    assign utick = (upre_q == TICK_CYC - 7'd1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            upre_q <= 7'h00;
            ucnt_q <= 16'h0000;
        end else if (ce) begin
            if (ivl_q == 16'h0000) begin
                upre_q <= 7'h00;                      // see RULE4
                ucnt_q <= 16'h0000;
            end else if (utick) begin
                upre_q <= 7'h00;
                // shrinking the interval mid-count still wraps at once
                ucnt_q <= (ucnt_q + 16'd1 >= ivl_q) ? 16'h0000
                                                     : ucnt_q + 16'd1;
            end else begin
                upre_q <= upre_q + 7'd1;
            end
        end
    end

    // update strobes, fine one suppressed under override
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fine_upd   <= 1'b0;
            coarse_upd <= 1'b0;
        end else if (ce) begin
            coarse_upd <= ivl_q != 16'h0000 && utick
                          && ucnt_q + 16'd1 >= ivl_q;         // see RULE3
            fine_upd   <= ivl_q != 16'h0000 && utick && !ovr_q
                          && ucnt_q + 16'd1 >= ivl_q;         // see RULE1
        end
    end

    // extrapolator: retriggered by every qualifying event
    logic [6:0]  xpre_q;  // cycles inside one tick
    logic [15:0] xcnt_q;  // ticks left

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xpre_q     <= 7'h00;
            xcnt_q     <= 16'h0000;
            extrap_run <= 1'b0;
        end else if (ce) begin
            if (qual_evt && ext_q != 16'h0000) begin  // see RULE6
                xpre_q     <= 7'h00;
                xcnt_q     <= ext_q;                  // see RULE5
                extrap_run <= 1'b1;
            end else if (extrap_run) begin
                if (xpre_q == TICK_CYC - 7'd1) begin
                    xpre_q <= 7'h00;
                    xcnt_q <= xcnt_q - 16'd1;
                    if (xcnt_q == 16'd1) begin
                        extrap_run <= 1'b0;           // see RULE5
                    end
                end else begin
                    xpre_q <= xpre_q + 7'd1;
                end
            end
        end
    end

    // sequencing hold: startup, then functional wakes
    atz_seq_t             st_q;    // sequencer state
    logic [SETTLE_W-1:0]  scnt_q;  // cycles held so far
    logic [SETTLE_W-1:0]  slim;    // limit of the current hold
    logic [SETTLE_W-1:0]  snext;   // count after this cycle

    assign slim  = (st_q == ST_WAKE) ? {3'h0, fws_q} : {sup_q, slo_q};
    assign snext = scnt_q + 19'd1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q     <= ST_START;
            scnt_q   <= 19'h00000;
            seq_hold <= 1'b1;
        end else if (ce) begin
            unique case (st_q)
                ST_START, ST_WAKE: begin
                    scnt_q <= snext;
                    if (snext >= slim) begin          // see RULE8
                        st_q     <= ST_RUN;
                        seq_hold <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (wake_func && fws_q != 16'h0000) begin
                        st_q     <= ST_WAKE;          // see RULE7
                        scnt_q   <= 19'h00000;
                        seq_hold <= 1'b1;
                    end
                end
                default: begin
                    st_q     <= ST_RUN;
                    seq_hold <= 1'b0;
                end
            endcase
        end
    end

    // dsp hold on battery-mode sleep to low-power wake
    logic [15:0] dcnt_q;  // cycles of dsp hold left

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dcnt_q   <= 16'h0000;
            dsp_hold <= 1'b0;
        end else if (ce) begin
            if (wake_lp && batt_mode && lps_q != 16'h0000) begin
                dcnt_q   <= lps_q;                    // see RULE9
                dsp_hold <= 1'b1;
            end else if (dsp_hold) begin
                dcnt_q <= dcnt_q - 16'd1;
                if (dcnt_q == 16'd1) begin
                    dsp_hold <= 1'b0;                 // see RULE9
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_ovr_dac;
        ce && ovr_q |=> fine_dac == $past(code_q);
    endproperty
    a_ovr_dac: assert property (p_ovr_dac) // see RULE1
        else $error("override code not on fine dac");

    property p_ovr_noupd;
        ovr_q && ce |=> !fine_upd;
    endproperty
    a_ovr_noupd: assert property (p_ovr_noupd) // see RULE1
        else $error("fine update while overridden");

    property p_uv;
        ce ##1 1 |-> fine_uv == 16'($signed($past(code_q)) * 250);
    endproperty
    a_uv: assert property (p_uv) // see RULE2
        else $error("fine offset microvolts wrong");

    property p_zero_ivl;
        ivl_q == 16'h0000 && ce |=> !coarse_upd && !fine_upd;
    endproperty
    a_zero_ivl: assert property (p_zero_ivl) // see RULE4
        else $error("update with zero interval");

    property p_ivl_one;
        ce && ivl_q == 16'd1 && utick |=> coarse_upd;
    endproperty
    a_ivl_one: assert property (p_ivl_one) // see RULE3
        else $error("interval strobe missing");

    property p_ext_zero;
        ext_q == 16'h0000 && !extrap_run |=> !extrap_run;
    endproperty
    a_ext_zero: assert property (p_ext_zero) // see RULE6
        else $error("extrapolator started with zero time");

    property p_ext_start;
        ce && qual_evt && ext_q != 16'h0000 |=> extrap_run && xcnt_q == $past(ext_q);
    endproperty
    a_ext_start: assert property (p_ext_start) // see RULE5
        else $error("extrapolator did not start");

    property p_wake;
        ce && st_q == ST_RUN && wake_func && fws_q != 16'h0000 |=> seq_hold && st_q == ST_WAKE;
    endproperty
    a_wake: assert property (p_wake) // see RULE7
        else $error("functional wake hold missing");

    property p_dsp;
        ce && wake_lp && batt_mode && lps_q == 16'd2 |=> dsp_hold ##1 (dsp_hold || !ce);
    endproperty
    a_dsp: assert property (p_dsp) // see RULE9
        else $error("dsp hold too short");

    property p_pos;
        ce |=> pos_out == $past(mech_angle) - $past({ixu_q, ixl_q});
    endproperty
    a_pos: assert property (p_pos) // see RULE10
        else $error("position offset wrong");

    property p_rsv;
        !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) // see RULE12
        else $error("reserved read bits not zero");

    c_write: cover property (wr && widx == IDX_FINE);
    c_ext:   cover property ($fell(extrap_run));
    c_start: cover property ($fell(seq_hold));
    c_dsp:   cover property ($fell(dsp_hold));

endmodule

// file: tb/atz_regs_tb_top.sv
// Purpose: self-checking bench for the trim, settle and index offset register bank
// Assumes: 20 MHz bench clock, bus answers after one wait cycle, ce high but once
// Notes:   long startup hold is shortened over the bus before the run-state tests

`timescale 1ns/1ps

module atz_regs_tb_top;
    import atz_pkg::*;

    logic        clk            = 1'b0;  // 50 ns bench clock
    logic        rst_n          = 1'b0;  // synchronous reset, active low
    logic        ce             = 1'b1;  // dropped once to show the freeze
    logic [9:0]  avs_address    = '0;    // byte address
    logic        avs_read       = 1'b0;  // read strobe
    logic        avs_write      = 1'b0;  // write strobe
    logic [31:0] avs_writedata  = '0;    // write data
    logic [3:0]  avs_byteenable = '0;    // byte lanes
    logic [31:0] avs_readdata;           // read data
    logic        avs_waitrequest;        // wait flag
    logic [7:0]  auto_fine_code = 8'h11; // automatic code, differs from any forced code
    logic        qual_evt       = 1'b0;  // extrapolator trigger
    logic        wake_func      = 1'b0;  // sleep to functional
    logic        wake_lp        = 1'b0;  // sleep to low power
    logic        batt_mode      = 1'b0;  // battery mode level
    logic [19:0] mech_angle     = '0;    // raw angle
    logic        nvm_load       = 1'b0;  // restore strobe
    logic [19:0] nvm_index      = '0;    // restored offset
    logic [7:0]  fine_dac;               // fine dac code
    logic        fine_ovr;               // override active
    logic signed [15:0] fine_uv;         // code in microvolts
    logic        fine_upd;               // fine update strobe
    logic        coarse_upd;             // coarse update strobe
    logic        extrap_run;             // extrapolator active
    logic        seq_hold;               // sequencing held
    logic        dsp_hold;               // dsp held
    logic [19:0] pos_out;                // offset angle
    logic [19:0] nvm_index_out;          // offset to nvm
    logic        nvm_store;              // store strobe
    int          error_cnt      = 0;     // mismatches
    int          cmp_count      = 0;     // comparisons
    int          store_cnt      = 0;     // nvm store pulses seen
    wire  [4:0]  mon            = {dsp_hold, seq_hold, extrap_run, fine_upd, coarse_upd};

    // register table: index, value after reset, bits that exist
    logic [7:0]  idx_tab [9] = '{IDX_FINE, IDX_IVL, IDX_EXT, IDX_FWS, IDX_SUP,
                                 IDX_SLO, IDX_LPS, IDX_IXU, IDX_IXL};
    logic [15:0] rst_tab [9] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_SUP,
                                 RST_SLO, RST_ZERO, RST_ZERO, RST_ZERO};
    logic [15:0] msk_tab [9] = '{16'h80ff, 16'hffff, 16'hffff, 16'hffff, 16'h0007,
                                 16'hffff, 16'hffff, 16'h000f, 16'hffff};

    atz_regs i_atz_regs (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .auto_fine_code(auto_fine_code),
        .qual_evt(qual_evt), .wake_func(wake_func), .wake_lp(wake_lp),
        .batt_mode(batt_mode), .mech_angle(mech_angle), .nvm_load(nvm_load),
        .nvm_index(nvm_index), .fine_dac(fine_dac), .fine_ovr(fine_ovr),
        .fine_uv(fine_uv), .fine_upd(fine_upd), .coarse_upd(coarse_upd),
        .extrap_run(extrap_run), .seq_hold(seq_hold), .dsp_hold(dsp_hold),
        .pos_out(pos_out), .nvm_index_out(nvm_index_out), .nvm_store(nvm_store));

    // free-running clock
    initial begin
        forever #25 clk = ~clk;
    end

    // count store strobes so a write can be tied to exactly one pulse
    always @(posedge clk) begin
        if (nvm_store === 1'b1) begin
            store_cnt <= store_cnt + 1;
        end
    end

    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle; held until waitrequest is sampled low, then an idle edge
    task automatic bus_cyc(input logic wr, input logic [7:0] idx, input logic [15:0] d,
                           input logic [3:0] be, output logic [31:0] q);
        int t;
        t = 0;
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        q = avs_readdata;
        if (t == 50) error_cnt++;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] q;
        bus_cyc(1'b1, idx, d, 4'h3, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] e);
        logic [31:0] q;
        bus_cyc(1'b0, idx, 16'h0000, 4'h3, q);
        check(name, q, {16'h0000, e});
    endtask

    // one-cycle pulse on an event input
    task automatic strobe(input int sel);
        case (sel)
            0: qual_evt <= 1'b1;
            1: wake_func <= 1'b1;
            2: wake_lp <= 1'b1;
            default: nvm_load <= 1'b1;
        endcase
        @(posedge clk);
        {qual_evt, wake_func, wake_lp, nvm_load} <= 4'h0;
    endtask

    // length of the next high run of a monitored output, zero if none starts
    task automatic run_len(input int sel, output int n);
        int t;
        t = 0;
        n = 0;
        while (mon[sel] !== 1'b1 && t < 10) begin @(posedge clk); t++; end
        while (mon[sel] === 1'b1 && n < 5000) begin @(posedge clk); n++; end
    endtask

    // cycles from one strobe to the next
    task automatic gap(input int sel, output int n);
        int t;
        t = 0;
        n = 1;
        while (mon[sel] !== 1'b1 && t < 1000) begin @(posedge clk); t++; end
        @(posedge clk);
        while (mon[sel] !== 1'b1 && n < 1000) begin @(posedge clk); n++; end
    endtask

    task automatic pulses(input int sel, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            if (mon[sel] === 1'b1) n++;
        end
    endtask

    task automatic t_reset_startup;
        for (int i = 0; i < 9; i++) rd_chk("reset value", idx_tab[i], rst_tab[i]);
        check("seq_hold at startup", mon[3], 1'b1);
        wr(IDX_SUP, 16'h0000);
        wr(IDX_SLO, 16'h0020);
        for (int t = 0; t < 100 && seq_hold !== 1'b0; t++) @(posedge clk);
        check("seq_hold released", seq_hold, 1'b0);
    endtask

    // every bit set, then read back; absent bits and an unmapped word stay zero
    task automatic t_reserved;
        logic [31:0] q;
        for (int i = 0; i < 9; i++) wr(idx_tab[i], 16'hffff);
        for (int i = 0; i < 9; i++) rd_chk("field mask", idx_tab[i], msk_tab[i]);
        for (int i = 0; i < 9; i++) wr(idx_tab[i], 16'h0000);
        wr(8'h49, 16'hffff);
        rd_chk("unmapped", 8'h49, 16'h0000);
        bus_cyc(1'b1, IDX_IXL, 16'haaaa, 4'h1, q);
        rd_chk("low lane only", IDX_IXL, 16'h00aa);
        wr(IDX_IXL, 16'h0000);
    endtask

    task automatic t_override_interval;
        int n;
        wr(IDX_FINE, 16'h8080);
        repeat (3) @(posedge clk);
        check("fine_dac forced", fine_dac, 8'h80);
        check("fine_ovr", fine_ovr, 1'b1);
        check("fine_uv", {16'h0000, fine_uv}, 16'h8300);
        wr(IDX_IVL, 16'h0002);
        gap(0, n);
        check("coarse period", n, 160);
        pulses(1, 400, n);
        check("fine strobes forced", n, 0);
        wr(IDX_FINE, 16'h007f);
        repeat (3) @(posedge clk);
        check("fine_dac auto", fine_dac, 8'h11);
        check("fine_ovr off", fine_ovr, 1'b0);
        gap(1, n);
        check("fine period", n, 160);
        wr(IDX_IVL, 16'h0001);
        gap(0, n);
        check("coarse period one", n, 80);
        wr(IDX_IVL, 16'h0000);
        repeat (5) @(posedge clk);
        pulses(0, 400, n);
        check("coarse strobes off", n, 0);
        pulses(1, 400, n);
        check("fine strobes off", n, 0);
    endtask

    task automatic t_extrap;
        int n;
        wr(IDX_EXT, 16'h0001);
        strobe(0);
        run_len(2, n);
        check("extrap run", n, 80);
        wr(IDX_EXT, 16'h0000);
        strobe(0);
        run_len(2, n);
        check("extrap zero", n, 0);
    endtask

    task automatic t_wake;
        int n;
        wr(IDX_FWS, 16'h0005);
        strobe(1);
        run_len(3, n);
        check("functional hold", n, 5);
        wr(IDX_LPS, 16'h0002);
        batt_mode <= 1'b1;
        strobe(2);
        run_len(4, n);
        check("low-power hold", n, 2);
        batt_mode <= 1'b0;
        strobe(2);
        run_len(4, n);
        check("no hold off battery", n, 0);
    endtask

    // the offset is taken off the angle; nvm gets one store pulse per write and can restore it
    task automatic t_index;
        int s;
        s = store_cnt;
        wr(IDX_IXU, 16'h0001);
        wr(IDX_IXL, 16'h2345);
        repeat (3) @(posedge clk);
        check("pos_out", {12'h000, pos_out}, 20'hedcbb);
        check("nvm_index_out", {12'h000, nvm_index_out}, 20'h12345);
        check("nvm stores", store_cnt - s, 2);
        nvm_index <= 20'h54321;
        strobe(3);
        rd_chk("restored upper", IDX_IXU, 16'h0005);
        rd_chk("restored lower", IDX_IXL, 16'h4321);
        mech_angle <= 20'h54321;
        repeat (3) @(posedge clk);
        check("pos_out zero", {12'h000, pos_out}, 20'h00000);
        ce         <= 1'b0;
        mech_angle <= 20'h00001;
        repeat (3) @(posedge clk);
        check("pos_out frozen", {12'h000, pos_out}, 20'h00000);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        check("pos_out resumed", {12'h000, pos_out}, 20'habce0);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_startup();
        t_reserved();
        t_override_interval();
        t_extrap();
        t_wake();
        t_index();
        end_sim();
    end

    // watchdog: the sequence needs a few thousand cycles
    initial begin
        #(20000 * 50);
        error_cnt++;
        end_sim();
    end

endmodule
